// ==== design/host_port_regs.vh ====
// address map, field positions and reset values for the octal uart host port
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define REG_IDX_MSB 3
`define CHAN_LSB 4
`define CHAN_MSB 6
`define GLOBAL_BIT 7
`define GLB_INT_SRC 4'h0
`define GLB_SCRATCH 4'h1
`define RESET_BYTE 8'h00
`endif

// ==== design/host_bus_port.v ====
// parallel host register port of an eight-channel uart, both bus styles
`timescale 1ns/1ps
`include "host_port_regs.vh"
module host_bus_port #(
    parameter CHANNELS = 8,
    parameter REGS = 16
) (
    // clock and reset
    input wire I_CLOCK,
    input wire I_NRST,
    // host bus
    input wire [7:0] I_HOST_ADDRESS,
    input wire [7:0] I_HOST_DATA_BUS,
    input wire I_READ_STROBE_N,
    input wire I_WRITE_STROBE_N,
    input wire I_CHIP_SELECT_N,
    input wire I_STYLE_SEPARATE,
    // channel interrupt requests
    input wire [CHANNELS-1:0] I_CHAN_IRQ,
    // host bus outputs
    output reg [7:0] O_HOST_DATA_BUS,
    output reg O_HOST_DATA_OE,
    output reg O_INT_N_OUT,
    output reg O_INT_N_OE
);
    // address field widths; the flat index below assumes sixteen registers per channel
    localparam IDX_W = `REG_IDX_MSB + 1;
    localparam CHAN_W = `CHAN_MSB - `CHAN_LSB + 1;
    localparam FLAT_W = IDX_W + CHAN_W;
    localparam DEPTH = CHANNELS * REGS;

    // per-channel register array; serial engines are outside this block
    reg [7:0] chan_reg [0:DEPTH-1];
    reg [7:0] glb_scratch;
    reg [CHANNELS-1:0] irq_src;
    // edge memory of the decoded strobes
    reg rd_prev;
    reg wr_prev;
    // write address taken at strobe fall, data sampled until strobe rise, both held for the commit
    reg [7:0] wr_addr;
    reg [7:0] wr_data;
    // combinational read path
    reg [7:0] next_rd_data;
    reg [7:0] next_irq_byte;
    // decoded strobes per bus style
    wire sep_rd;
    wire sep_wr;
    wire comb_rd;
    wire comb_wr;
    wire rd_active;
    wire wr_active;
    wire rd_start;
    wire wr_start;
    wire wr_commit;
    // live address fields used by reads
    wire [IDX_W-1:0] rd_reg_idx;
    wire [CHAN_W-1:0] rd_chan;
    wire rd_global;
    wire [FLAT_W-1:0] chan_index;
    // held address fields used by writes
    wire [IDX_W-1:0] wr_reg_idx;
    wire [CHAN_W-1:0] wr_chan;
    wire wr_global;
    wire [FLAT_W-1:0] wr_index;
    wire wr_to_scratch;
    wire irq_any;
    integer k;
    integer b;

    // separate-strobe style: chip select enables, each direction has its own strobe
    assign sep_rd = !I_CHIP_SELECT_N && !I_READ_STROBE_N;
    assign sep_wr = !I_CHIP_SELECT_N && !I_WRITE_STROBE_N;

    // combined style: chip select is the only strobe, write input gives the direction
    assign comb_rd = !I_CHIP_SELECT_N && I_WRITE_STROBE_N;
    assign comb_wr = !I_CHIP_SELECT_N && !I_WRITE_STROBE_N;

    // the read strobe pin is ignored in combined style, so a weak tie cannot fake a read
    assign rd_active = I_STYLE_SEPARATE ? sep_rd : comb_rd;
    assign wr_active = I_STYLE_SEPARATE ? sep_wr : comb_wr;

    // one-cycle markers: first active edge starts a cycle, first idle edge ends a write
    assign rd_start = rd_active && !rd_prev;
    assign wr_start = wr_active && !wr_prev;
    assign wr_commit = !wr_active && wr_prev;

    // live address split into register, channel and global select
    assign rd_reg_idx = I_HOST_ADDRESS[`REG_IDX_MSB:0];
    assign rd_chan = I_HOST_ADDRESS[`CHAN_MSB:`CHAN_LSB];
    assign rd_global = I_HOST_ADDRESS[`GLOBAL_BIT];
    assign chan_index = {rd_chan, rd_reg_idx};

    // the same split of the address captured when the write strobe fell
    assign wr_reg_idx = wr_addr[`REG_IDX_MSB:0];
    assign wr_chan = wr_addr[`CHAN_MSB:`CHAN_LSB];
    assign wr_global = wr_addr[`GLOBAL_BIT];
    assign wr_index = {wr_chan, wr_reg_idx};

    // only the scratch byte takes writes among the globals; the source register is read only
    assign wr_to_scratch = wr_global && (wr_reg_idx == `GLB_SCRATCH);

    // any channel request pulls the shared line; other devices may pull it as well
    assign irq_any = |I_CHAN_IRQ;

    // request bits packed into a byte; channels past the eighth do not fit and are not shown
    always @* begin
        next_irq_byte = `RESET_BYTE;
        for (b = 0; b < 8; b = b + 1) begin
            if (b < CHANNELS) begin
                next_irq_byte[b] = irq_src[b];
            end
        end
    end

    // read mux: globals on top bit, channel register otherwise
    always @* begin
        next_rd_data = `RESET_BYTE;
        if (rd_global) begin
            if (rd_reg_idx == `GLB_INT_SRC) begin
                next_rd_data = next_irq_byte;
            end else if (rd_reg_idx == `GLB_SCRATCH) begin
                next_rd_data = glb_scratch;
            end
        end else begin
            next_rd_data = chan_reg[chan_index];
        end
    end

    // read side: byte latched at strobe fall and held until it ends.
    // latching once keeps the byte steady even if a source changes mid-cycle.
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rd_prev <= 1'b0;
            O_HOST_DATA_BUS <= `RESET_BYTE;
        end else begin
            rd_prev <= rd_active;
            if (rd_start) begin
                O_HOST_DATA_BUS <= next_rd_data;
            end
        end
    end

    // bus drive enable follows the decoded read with one cycle of lag;
    // the host should leave one idle cycle before driving after a read
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_HOST_DATA_OE <= 1'b0;
        end else begin
            O_HOST_DATA_OE <= rd_active;
        end
    end

    // write capture: address at strobe fall, data every active cycle so the last value wins
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_prev <= 1'b0;
            wr_addr <= `RESET_BYTE;
            wr_data <= `RESET_BYTE;
        end else begin
            wr_prev <= wr_active;
            if (wr_start) begin
                wr_addr <= I_HOST_ADDRESS;
            end
            if (wr_active) begin
                wr_data <= I_HOST_DATA_BUS;
            end
        end
    end

    // global scratch byte, written on the trailing edge of the write strobe
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            glb_scratch <= `RESET_BYTE;
        end else begin
            if (wr_commit && wr_to_scratch) begin
                glb_scratch <= wr_data;
            end
        end
    end

    // channel registers, written on the trailing edge of the write strobe;
    // the async clear of the whole array costs area but gives a known read after reset
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                chan_reg[k] <= `RESET_BYTE;
            end
        end else begin
            if (wr_commit && !wr_global) begin
                chan_reg[wr_index] <= wr_data;
            end
        end
    end

    // interrupt source: live request levels sampled each cycle, so no clear can race
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq_src <= {CHANNELS{1'b0}};
        end else begin
            irq_src <= I_CHAN_IRQ;
        end
    end

    // open-drain pin: data held low, only the enable moves, so the pin never drives high
    always @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_INT_N_OUT <= 1'b0;
            O_INT_N_OE <= 1'b0;
        end else begin
            O_INT_N_OUT <= 1'b0;
            O_INT_N_OE <= irq_any;
        end
    end
endmodule

// ==== sim/host_bus_port_asserts.sv ====
// pin checks for the host bus port
`timescale 1ns/1ps
module host_bus_port_asserts #(parameter CHANNELS = 8) (input wire I_CLOCK, I_NRST,
    I_READ_STROBE_N, I_WRITE_STROBE_N, I_CHIP_SELECT_N, I_STYLE_SEPARATE, O_HOST_DATA_OE,
    O_INT_N_OUT, O_INT_N_OE, input wire [7:0] O_HOST_DATA_BUS,
    input wire [CHANNELS-1:0] I_CHAN_IRQ);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    // decoded read for both styles; a write is chip select plus low write input in either
    wire rd = !I_CHIP_SELECT_N && (I_STYLE_SEPARATE ? !I_READ_STROBE_N : I_WRITE_STROBE_N);
    wire wr = !I_CHIP_SELECT_N && !I_WRITE_STROBE_N;
    sequence s_rd; !rd ##1 rd; endsequence
    property p_rd; s_rd |=> O_HOST_DATA_OE; endproperty
    a_rd: assert property (p_rd) else $error("read start not driven");
    property p_hold; rd ##1 rd |=> $stable(O_HOST_DATA_BUS); endproperty
    a_hold: assert property (p_hold) else $error("read byte moved");
    property p_idle; !rd |=> !O_HOST_DATA_OE; endproperty
    a_idle: assert property (p_idle) else $error("bus driven while idle");
    property p_wr; wr |=> !O_HOST_DATA_OE; endproperty
    a_wr: assert property (p_wr) else $error("bus driven in write");
    property p_cs; I_CHIP_SELECT_N |=> !O_HOST_DATA_OE; endproperty
    a_cs: assert property (p_cs) else $error("driven without select");
    property p_sep; I_STYLE_SEPARATE && !I_CHIP_SELECT_N && !I_READ_STROBE_N |=> O_HOST_DATA_OE;
    endproperty
    a_sep: assert property (p_sep) else $error("read strobe ignored");
    property p_comb; !I_STYLE_SEPARATE && !I_CHIP_SELECT_N && I_WRITE_STROBE_N |=> O_HOST_DATA_OE;
    endproperty
    a_comb: assert property (p_comb) else $error("combined read ignored");
    property p_int; !O_INT_N_OUT && O_INT_N_OE == |$past(I_CHAN_IRQ); endproperty
    a_int: assert property (p_int) else $error("interrupt line wrong");
endmodule
bind host_bus_port host_bus_port_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .I_CLOCK(I_CLOCK),
    .I_NRST(I_NRST),
    .I_READ_STROBE_N(I_READ_STROBE_N),
    .I_WRITE_STROBE_N(I_WRITE_STROBE_N),
    .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
    .I_STYLE_SEPARATE(I_STYLE_SEPARATE),
    .O_HOST_DATA_OE(O_HOST_DATA_OE),
    .O_INT_N_OUT(O_INT_N_OUT),
    .O_INT_N_OE(O_INT_N_OE),
    .O_HOST_DATA_BUS(O_HOST_DATA_BUS),
    .I_CHAN_IRQ(I_CHAN_IRQ)
);

// ==== sim/host_model.sv ====
// host processor model driving the parallel bus
`timescale 1ns/1ps
module host_model (input wire I_CLOCK, input wire [7:0] O_HOST_DATA_BUS,
    output logic [7:0] I_HOST_ADDRESS = 8'h00, I_HOST_DATA_BUS = 8'h00,
    output logic I_READ_STROBE_N = 1'b1, I_WRITE_STROBE_N = 1'b1, I_CHIP_SELECT_N = 1'b1,
    output logic I_STYLE_SEPARATE = 1'b1);
    logic [7:0] rdata;
    // request held three edges, byte taken at the last, then one idle cycle
    task automatic xfer(input logic s, w, c, input logic [7:0] ad, wd);
        @(posedge I_CLOCK) #2;
        {I_STYLE_SEPARATE, I_HOST_ADDRESS, I_HOST_DATA_BUS, I_CHIP_SELECT_N} = {s, ad, wd, !c};
        {I_READ_STROBE_N, I_WRITE_STROBE_N} = {!s || w, !w};
        repeat (3) @(posedge I_CLOCK);
        rdata = O_HOST_DATA_BUS;
        #2 {I_READ_STROBE_N, I_WRITE_STROBE_N, I_CHIP_SELECT_N} = 3'b111;
        I_HOST_DATA_BUS = ~wd; // a released bus must not keep showing the last byte
        @(posedge I_CLOCK) #2;
    endtask
endmodule

// ==== sim/test_host_bus_port.sv ====
// self-checking bench for the host bus port against a reference model
`timescale 1ns/1ps
module test_host_bus_port;
    logic I_CLOCK = 1'b0, I_NRST = 1'b0;
    logic [7:0] I_CHAN_IRQ = 8'h00, ad, ex;
    logic [7:0] mem [0:255];
    logic [31:0] r;
    wire [7:0] I_HOST_ADDRESS, I_HOST_DATA_BUS, O_HOST_DATA_BUS;
    wire I_READ_STROBE_N, I_WRITE_STROBE_N, I_CHIP_SELECT_N, I_STYLE_SEPARATE;
    wire O_HOST_DATA_OE, O_INT_N_OUT, O_INT_N_OE;
    integer err_count = 0, total_checks = 0, cycles = 0, seed = 32'hF81CA8B3, i;
    initial forever #25 I_CLOCK = ~I_CLOCK;
    host_model u_host (
        .I_CLOCK(I_CLOCK),
        .O_HOST_DATA_BUS(O_HOST_DATA_BUS),
        .I_HOST_ADDRESS(I_HOST_ADDRESS),
        .I_HOST_DATA_BUS(I_HOST_DATA_BUS),
        .I_READ_STROBE_N(I_READ_STROBE_N),
        .I_WRITE_STROBE_N(I_WRITE_STROBE_N),
        .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
        .I_STYLE_SEPARATE(I_STYLE_SEPARATE)
    );
    host_bus_port u_dut (
        .I_CLOCK(I_CLOCK),
        .I_NRST(I_NRST),
        .I_HOST_ADDRESS(I_HOST_ADDRESS),
        .I_HOST_DATA_BUS(I_HOST_DATA_BUS),
        .I_READ_STROBE_N(I_READ_STROBE_N),
        .I_WRITE_STROBE_N(I_WRITE_STROBE_N),
        .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
        .I_STYLE_SEPARATE(I_STYLE_SEPARATE),
        .I_CHAN_IRQ(I_CHAN_IRQ),
        .O_HOST_DATA_BUS(O_HOST_DATA_BUS),
        .O_HOST_DATA_OE(O_HOST_DATA_OE),
        .O_INT_N_OUT(O_INT_N_OUT),
        .O_INT_N_OE(O_INT_N_OE)
    );
    task automatic check(input string n, input logic [7:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge I_CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end
    // random traffic in both styles; globals limited to offsets 0 to 3
    initial begin
        for (i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (16) @(posedge I_CLOCK);
        #2 I_NRST = 1'b1;
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            I_CHAN_IRQ = r[31:24];
            ad = r[7] ? (r[7:0] & 8'h83) : r[7:0];
            u_host.xfer(r[8], r[9], r[12:10] != 3'h0, ad, r[23:16]);
            ex = !ad[7] ? mem[ad] : ad == 8'h80 ? I_CHAN_IRQ : ad == 8'h81 ? mem[ad] : 8'h00;
            if (r[12:10] != 3'h0 && !r[9]) check("read byte", u_host.rdata, ex);
            if (r[12:10] != 3'h0 && r[9] && (!ad[7] || ad == 8'h81)) mem[ad] = r[23:16];
            check("bus enable", {7'h00, O_HOST_DATA_OE}, 8'h00);
            check("interrupt", {6'h00, O_INT_N_OUT, O_INT_N_OE}, {7'h00, |I_CHAN_IRQ});
        end
        results();
    end
endmodule
